// ===== src/adc_cfg_regs.vh
// Offsets, fields, reset values and page codes for the configuration bank
`ifndef ADC_CFG_REGS_VH
`define ADC_CFG_REGS_VH

`define ADDR_W              8
`define DATA_W              8

`define OFF_SOFT_RESET      8'h00
`define OFF_LINK_PAGE_LO    8'h03
`define OFF_LINK_PAGE_HI    8'h04
`define OFF_CHAN_WR_MODE    8'h05
`define OFF_CONV_PAGE       8'h11
`define OFF_CORE_SET_ONE    8'h20
`define OFF_BUF_SET_ONE     8'h21
`define OFF_CORE_SET_TWO    8'h23
`define OFF_BUF_SET_TWO     8'h24
`define OFF_PDN_CTRL        8'h26
`define OFF_MASK_EN         8'h55

`define BIT_RESET_HI        7
`define BIT_RESET_LO        0
`define BIT_PAIR_WRITE_OFF  0
`define BIT_SET_CHOICE      5
`define BIT_MASK_EN         0

`define CORE_A_HI           7
`define CORE_A_LO           4
`define CORE_B_HI           3
`define CORE_B_LO           0
`define BUF_B_HI            7
`define BUF_B_LO            6
`define BUF_A_HI            5
`define BUF_A_LO            4
`define BUF_FIELD_MASK      8'hF0

`define RST_BYTE            8'h00
`define RST_BIT             1'b0

`define LINK_PAGE_MAIN      16'h6800
`define LINK_PAGE_DIGITAL   16'h6900
`define LINK_PAGE_ANALOG    16'h6A00
`define CONV_PAGE_MASTER    8'h80
`define CONV_PAGE_CORE      8'h0F

`endif

// ===== src/shutdown_mask_pick.v
// Picks the active power-down mask set and gates it by the mask enable
`include "adc_cfg_regs.vh"

module shutdown_mask_pick (
  // Mask sets
  input  wire [7:0] core_set_one_i,
  input  wire [7:0] buf_set_one_i,
  input  wire [7:0] core_set_two_i,
  input  wire [7:0] buf_set_two_i,
  // Controls
  input  wire       set_choice_i,
  input  wire       mask_en_i,
  // Per-channel shutdown
  output wire [3:0] core_off_chan_a_o,
  output wire [3:0] core_off_chan_b_o,
  output wire [1:0] buffer_off_chan_a_o,
  output wire [1:0] buffer_off_chan_b_o
);

  wire [7:0] core_sel;
  wire [7:0] buf_sel;

  assign core_sel = set_choice_i ? core_set_two_i : core_set_one_i;  // see RULE8 see RULE12
  assign buf_sel  = set_choice_i ? buf_set_two_i  : buf_set_one_i;

  // see RULE7 see RULE9
  assign core_off_chan_a_o   = mask_en_i ? core_sel[`CORE_A_HI:`CORE_A_LO] : 4'h0;
  assign core_off_chan_b_o   = mask_en_i ? core_sel[`CORE_B_HI:`CORE_B_LO] : 4'h0;
  // Field 00 keeps both buffers on, 11 shuts both; see RULE10 see RULE11
  assign buffer_off_chan_a_o = mask_en_i ? buf_sel[`BUF_A_HI:`BUF_A_LO] : 2'h0;
  assign buffer_off_chan_b_o = mask_en_i ? buf_sel[`BUF_B_HI:`BUF_B_LO] : 2'h0;

endmodule // shutdown_mask_pick

// ===== src/adc_page_select_and_powerdown_regs.v
// General configuration bank: soft reset, page selectors, channel write steering, power-down masks
//
// What this block does
// RULE1 - Writing one to bit 7 or bit 0 of reset register pulses soft reset.
// RULE2 - Link bank page selector is 16 bits: low byte at 3h, high at 4h.
// RULE3 - Page 6800h main digital, 6900h link digital, 6A00h link analog.
// RULE4 - With pair-write-off clear, paged writes go to both channels together.
// RULE5 - With pair-write-off set, channel pick bit steers writes to A or B.
// RULE6 - Converter page at 11h: 80h master page, 0Fh converter page; resets zero.
// RULE7 - Power-down masks only act while the mask-enable bit at 55h is set.
// RULE8 - Bit 5 of 26h picks mask set 20h/21h or set 23h/24h.
// RULE9 - Core mask bits 7-4 shut channel A cores, bits 3-0 channel B.
// RULE10 - Buffer field 00 keeps both buffers of the channel running.
// RULE11 - Buffer field 11 shuts both buffers; B at bits 7-6, A at 5-4.
// RULE12 - Mask-select bit zero picks set one, one picks set two; resets zero.
// RULE13 - Host sets pin override before programming the global power-down bit.
// RULE14 - Host writes zero to reserved bits; the bank ignores them. The host model passes bit 7 of 26h through and forces bit 6 to one.
`include "adc_cfg_regs.vh"

module adc_page_select_and_powerdown_regs (
  // Clock and reset
  input  wire        core_clk_i,
  input  wire        rst_i,
  // Decoded serial port access
  input  wire        wr_en_i,
  input  wire        rd_en_i,
  input  wire [7:0]  addr_i,
  input  wire [7:0]  wr_data_i,
  input  wire        channel_pick_bit_i,
  output reg  [7:0]  rd_data_o,
  output reg         rd_valid_o,
  // Soft reset
  output reg         soft_reset_o,
  // Page selects
  output reg  [15:0] link_bank_page_selector_o,
  output reg         link_page_main_o,
  output reg         link_page_digital_o,
  output reg         link_page_analog_o,
  output reg         conv_page_master_o,
  output reg         conv_page_core_o,
  // Paged write forwarding
  output reg         chan_a_wr_o,
  output reg         chan_b_wr_o,
  output reg  [7:0]  paged_addr_o,
  output reg  [7:0]  paged_data_o,
  // Power-down
  output reg  [3:0]  core_off_chan_a_o,
  output reg  [3:0]  core_off_chan_b_o,
  output reg  [1:0]  buffer_off_chan_a_o,
  output reg  [1:0]  buffer_off_chan_b_o
);

  reg  [7:0] link_page_lo_reg;
  reg  [7:0] link_page_hi_reg;
  reg        pair_write_off_reg;
  reg  [7:0] conv_page_reg;
  reg  [7:0] core_set_one_reg;
  reg  [7:0] buf_set_one_reg;
  reg  [7:0] core_set_two_reg;
  reg  [7:0] buf_set_two_reg;
  reg        set_choice_reg;
  reg        mask_en_reg;

  wire [15:0] page_next;
  wire        master_on;
  wire        general_wr;
  wire        master_wr;
  wire        fire_reset;
  wire [3:0]  core_a_next;
  wire [3:0]  core_b_next;
  wire [1:0]  buf_a_next;
  wire [1:0]  buf_b_next;
  reg  [7:0]  rd_next;

  // Address belongs to the general bank, reachable on every page
  function is_general;
    input [7:0] a;
    begin
      is_general = (a == `OFF_SOFT_RESET) || (a == `OFF_LINK_PAGE_LO) || (a == `OFF_LINK_PAGE_HI) ||
                   (a == `OFF_CHAN_WR_MODE) || (a == `OFF_CONV_PAGE);
    end
  endfunction

  // Address belongs to the master page bank held here
  function is_master;
    input [7:0] a;
    begin
      is_master = (a == `OFF_CORE_SET_ONE) || (a == `OFF_BUF_SET_ONE) || (a == `OFF_CORE_SET_TWO) ||
                  (a == `OFF_BUF_SET_TWO) || (a == `OFF_PDN_CTRL) || (a == `OFF_MASK_EN);
    end
  endfunction

  assign page_next  = {link_page_hi_reg, link_page_lo_reg};  // see RULE2
  assign master_on  = (conv_page_reg == `CONV_PAGE_MASTER);  // see RULE6
  assign general_wr = wr_en_i && is_general(addr_i);
  assign master_wr  = wr_en_i && master_on && is_master(addr_i);
  // see RULE1
  assign fire_reset = wr_en_i && (addr_i == `OFF_SOFT_RESET) &&
                      (wr_data_i[`BIT_RESET_HI] || wr_data_i[`BIT_RESET_LO]);

  shutdown_mask_pick u_mask_pick (
    .core_set_one_i      (core_set_one_reg),
    .buf_set_one_i       (buf_set_one_reg),
    .core_set_two_i      (core_set_two_reg),
    .buf_set_two_i       (buf_set_two_reg),
    .set_choice_i        (set_choice_reg),
    .mask_en_i           (mask_en_reg),
    .core_off_chan_a_o   (core_a_next),
    .core_off_chan_b_o   (core_b_next),
    .buffer_off_chan_a_o (buf_a_next),
    .buffer_off_chan_b_o (buf_b_next)
  );

  // Register storage; soft reset returns the bank to its reset state
  always @(posedge core_clk_i)
  begin
    if (rst_i || fire_reset)
    begin
      link_page_lo_reg   <= `RST_BYTE;
      link_page_hi_reg   <= `RST_BYTE;
      pair_write_off_reg <= `RST_BIT;
      conv_page_reg      <= `RST_BYTE;
      core_set_one_reg   <= `RST_BYTE;
      buf_set_one_reg    <= `RST_BYTE;
      core_set_two_reg   <= `RST_BYTE;
      buf_set_two_reg    <= `RST_BYTE;
      set_choice_reg     <= `RST_BIT;  // see RULE12
      mask_en_reg        <= `RST_BIT;
    end
    else
    begin
      if (general_wr)
      begin
        case (addr_i)
          `OFF_LINK_PAGE_LO: link_page_lo_reg   <= wr_data_i;
          `OFF_LINK_PAGE_HI: link_page_hi_reg   <= wr_data_i;
          `OFF_CHAN_WR_MODE: pair_write_off_reg <= wr_data_i[`BIT_PAIR_WRITE_OFF];
          `OFF_CONV_PAGE:    conv_page_reg      <= wr_data_i;  // see RULE6
          default:           ;
        endcase
      end
      if (master_wr)
      begin
        case (addr_i)
          `OFF_CORE_SET_ONE: core_set_one_reg <= wr_data_i;
          `OFF_BUF_SET_ONE:  buf_set_one_reg  <= wr_data_i & `BUF_FIELD_MASK;  // see RULE14
          `OFF_CORE_SET_TWO: core_set_two_reg <= wr_data_i;
          `OFF_BUF_SET_TWO:  buf_set_two_reg  <= wr_data_i & `BUF_FIELD_MASK;
          `OFF_PDN_CTRL:     set_choice_reg   <= wr_data_i[`BIT_SET_CHOICE];  // see RULE8
          `OFF_MASK_EN:      mask_en_reg      <= wr_data_i[`BIT_MASK_EN];  // see RULE7
          default:           ;
        endcase
      end
    end
  end

  // Read mux; reset register reads zero since it clears itself
  always @*
  begin
    rd_next = `RST_BYTE;
    case (addr_i)
      `OFF_LINK_PAGE_LO: rd_next = link_page_lo_reg;
      `OFF_LINK_PAGE_HI: rd_next = link_page_hi_reg;
      `OFF_CHAN_WR_MODE: rd_next = {7'h00, pair_write_off_reg} << `BIT_PAIR_WRITE_OFF;
      `OFF_CONV_PAGE:    rd_next = conv_page_reg;
      default:
      begin
        if (master_on && is_master(addr_i))
        begin
          case (addr_i)
            `OFF_CORE_SET_ONE: rd_next = core_set_one_reg;
            `OFF_BUF_SET_ONE:  rd_next = buf_set_one_reg;
            `OFF_CORE_SET_TWO: rd_next = core_set_two_reg;
            `OFF_BUF_SET_TWO:  rd_next = buf_set_two_reg;
            `OFF_PDN_CTRL:     rd_next = {7'h00, set_choice_reg} << `BIT_SET_CHOICE;
            `OFF_MASK_EN:      rd_next = {7'h00, mask_en_reg} << `BIT_MASK_EN;
            default:           rd_next = `RST_BYTE;
          endcase
        end
      end
    endcase
  end

  // Registered outputs
  always @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      rd_data_o                 <= `RST_BYTE;
      rd_valid_o                <= 1'b0;
      soft_reset_o              <= 1'b0;
      link_bank_page_selector_o <= 16'h0000;
      link_page_main_o          <= 1'b0;
      link_page_digital_o       <= 1'b0;
      link_page_analog_o        <= 1'b0;
      conv_page_master_o        <= 1'b0;
      conv_page_core_o          <= 1'b0;
      chan_a_wr_o               <= 1'b0;
      chan_b_wr_o               <= 1'b0;
      paged_addr_o              <= `RST_BYTE;
      paged_data_o              <= `RST_BYTE;
      core_off_chan_a_o         <= 4'h0;
      core_off_chan_b_o         <= 4'h0;
      buffer_off_chan_a_o       <= 2'h0;
      buffer_off_chan_b_o       <= 2'h0;
    end
    else
    begin
      rd_data_o                 <= rd_en_i ? rd_next : `RST_BYTE;
      rd_valid_o                <= rd_en_i;
      soft_reset_o              <= fire_reset;  // see RULE1
      link_bank_page_selector_o <= page_next;
      link_page_main_o          <= (page_next == `LINK_PAGE_MAIN);  // see RULE3
      link_page_digital_o       <= (page_next == `LINK_PAGE_DIGITAL);
      link_page_analog_o        <= (page_next == `LINK_PAGE_ANALOG);
      conv_page_master_o        <= master_on;  // see RULE6
      conv_page_core_o          <= (conv_page_reg == `CONV_PAGE_CORE);
      // Paged writes: pair unless pair-write is off; see RULE4 see RULE5
      chan_a_wr_o  <= wr_en_i && !general_wr && !master_wr && (!pair_write_off_reg || !channel_pick_bit_i);
      chan_b_wr_o  <= wr_en_i && !general_wr && !master_wr && (!pair_write_off_reg || channel_pick_bit_i);
      paged_addr_o <= addr_i;
      paged_data_o <= wr_data_i;
      core_off_chan_a_o   <= core_a_next;
      core_off_chan_b_o   <= core_b_next;
      buffer_off_chan_a_o <= buf_a_next;
      buffer_off_chan_b_o <= buf_b_next;
    end
  end

endmodule // adc_page_select_and_powerdown_regs

// ===== tb/adc_cfg_regs_asserts.sv
// Port checker for the configuration bank
module adc_cfg_regs_asserts (
  // Access
  input wire logic        core_clk_i,
  input wire logic        rst_i,
  input wire logic        wr_en_i,
  input wire logic        rd_en_i,
  input wire logic [7:0]  addr_i,
  input wire logic [7:0]  wr_data_i,
  input wire logic        channel_pick_bit_i,
  // Outputs
  input wire logic [7:0]  rd_data_o,
  input wire logic        rd_valid_o,
  input wire logic        soft_reset_o,
  input wire logic [15:0] link_bank_page_selector_o,
  input wire logic        link_page_main_o,
  input wire logic        conv_page_master_o,
  input wire logic        chan_a_wr_o,
  input wire logic        chan_b_wr_o,
  input wire logic [7:0]  paged_addr_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic pair_off_reg;
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  // Shadow of the pair-write-off bit
  always @(posedge core_clk_i)
    if (rst_i || (wr_en_i && addr_i == 8'h00 && (wr_data_i[7] || wr_data_i[0])))
      pair_off_reg <= 1'b0;
    else if (wr_en_i && addr_i == 8'h05)
      pair_off_reg <= wr_data_i[0];
  sequence s_soft_req;
    wr_en_i && addr_i == 8'h00 && (wr_data_i[7] || wr_data_i[0]);
  endsequence
  sequence s_one_pulse;
    soft_reset_o ##1 !soft_reset_o;
  endsequence
  a_read_latency: assert property (rd_valid_o == $past(rd_en_i))
    else $error("read answer not one cycle after request");
  a_read_idle_zero: assert property (!rd_valid_o |-> rd_data_o == 8'h00)
    else $error("read data not zero while idle");
  a_soft_pulse: assert property (s_soft_req |=> s_one_pulse)
    else $error("soft reset pulse missing or too long");
  a_soft_cause: assert property (soft_reset_o |-> $past(wr_en_i) && $past(addr_i) == 8'h00)
    else $error("soft reset without a reset write");
  a_page_main: assert property (link_page_main_o == (link_bank_page_selector_o == 16'h6800))
    else $error("main page flag disagrees with selector");
  a_pair_both: assert property (wr_en_i && addr_i == 8'h41 && !pair_off_reg |=> chan_a_wr_o && chan_b_wr_o)
    else $error("paired write not sent to both channels");
  a_pick_steer: assert property (wr_en_i && addr_i == 8'h41 && pair_off_reg
    |=> chan_b_wr_o == $past(channel_pick_bit_i) && chan_a_wr_o != $past(channel_pick_bit_i))
    else $error("single channel write steered wrongly");
  a_paged_addr: assert property (chan_a_wr_o || chan_b_wr_o |-> paged_addr_o == $past(addr_i))
    else $error("forwarded address differs");
  a_conv_master: assert property (wr_en_i && addr_i == 8'h11
    |=> ##1 conv_page_master_o == ($past(wr_data_i, 2) == 8'h80))
    else $error("master page flag wrong after page write");
endmodule // adc_cfg_regs_asserts

bind adc_page_select_and_powerdown_regs adc_cfg_regs_asserts i_chk (.core_clk_i, .rst_i, .wr_en_i, .rd_en_i,
  .addr_i, .wr_data_i, .channel_pick_bit_i, .rd_data_o, .rd_valid_o, .soft_reset_o, .link_bank_page_selector_o,
  .link_page_main_o, .conv_page_master_o, .chan_a_wr_o, .chan_b_wr_o, .paged_addr_o);

// ===== tb/host_model.sv
// Host side of the decoded register port
module host_model (
  input  wire logic core_clk_i,
  output logic      wr_en_o = 1'b0,
  output logic      rd_en_o = 1'b0,
  output logic[7:0] addr_o = 8'h00,
  output logic[7:0] wr_data_o = 8'h00,
  output logic      pick_o = 1'b0
);
  timeunit 1ns;
  timeprecision 1ps;
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic p);
    logic [7:0] v;
    v = d;
    if (a == 8'h00) v = d & 8'h81;
    if (a == 8'h05) v = d & 8'h01;
    if (a == 8'h21 || a == 8'h24) v = d & 8'hF0;
    if (a == 8'h26) v = (d & 8'hE0) | 8'h40;
    @(negedge core_clk_i);
    wr_en_o = 1'b1;
    addr_o = a;
    wr_data_o = v;
    pick_o = p;
    @(negedge core_clk_i);
    wr_en_o = 1'b0;
    addr_o = ~a;
    wr_data_o = ~v;
    pick_o = ~p;
  endtask
  task automatic rd(input logic [7:0] a);
    @(negedge core_clk_i);
    rd_en_o = 1'b1;
    addr_o = a;
    @(negedge core_clk_i);
    rd_en_o = 1'b0;
    addr_o = ~a;
  endtask
endmodule // host_model

// ===== tb/testbench.sv
// Self-checking bench for the configuration bank
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wr_en_i, rd_en_i, channel_pick_bit_i, rd_valid_o, soft_reset_o, link_page_main_o, link_page_digital_o;
  logic link_page_analog_o, conv_page_master_o, conv_page_core_o, chan_a_wr_o, chan_b_wr_o;
  logic [7:0] addr_i, wr_data_i, rd_data_o, paged_addr_o, paged_data_o, rnd;
  logic [15:0] link_bank_page_selector_o;
  logic [3:0] core_off_chan_a_o, core_off_chan_b_o;
  logic [1:0] buffer_off_chan_a_o, buffer_off_chan_b_o;
  int mismatches = 0;
  int num_checks = 0;
  logic [7:0] exp_q[$];
  logic [15:0] pages[3] = '{16'h6800, 16'h6900, 16'h6A00};
  logic [7:0] core_val[3] = '{8'h0F, 8'hF0, 8'hFF};
  logic [7:0] idle_addr[5] = '{8'h03, 8'h04, 8'h05, 8'h11, 8'h7E};
  logic [7:0] rst_val[2] = '{8'h80, 8'h01};
  always #25 core_clk_i = ~core_clk_i;
  host_model i_host (.core_clk_i, .wr_en_o(wr_en_i), .rd_en_o(rd_en_i), .addr_o(addr_i), .wr_data_o(wr_data_i),
    .pick_o(channel_pick_bit_i));
  adc_page_select_and_powerdown_regs i_dut (.core_clk_i, .rst_i, .wr_en_i, .rd_en_i, .addr_i, .wr_data_i,
    .channel_pick_bit_i, .rd_data_o, .rd_valid_o, .soft_reset_o, .link_bank_page_selector_o, .link_page_main_o,
    .link_page_digital_o, .link_page_analog_o, .conv_page_master_o, .conv_page_core_o, .chan_a_wr_o,
    .chan_b_wr_o, .paged_addr_o, .paged_data_o, .core_off_chan_a_o, .core_off_chan_b_o, .buffer_off_chan_a_o,
    .buffer_off_chan_b_o);
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict;
    $display("Checks %0d, mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    i_host.rd(a);
  endtask
  // Read answers against the oldest note
  always @(negedge core_clk_i)
    if (rd_valid_o === 1'b1)
    begin
      check(16'(exp_q.size() > 0), 16'h0001);
      check(16'(rd_data_o), 16'(exp_q.pop_front()));
    end
  task automatic masks(input logic [11:0] e);
    @(negedge core_clk_i);
    check(16'({core_off_chan_a_o, core_off_chan_b_o, buffer_off_chan_b_o, buffer_off_chan_a_o}), 16'(e));
  endtask
  initial
  begin
    #1ms;
    mismatches++;
    give_verdict();
  end
  initial
  begin
    void'($urandom(32'h5480));
    repeat (16) @(negedge core_clk_i);
    rst_i = 1'b0;
    foreach (idle_addr[i]) rd(idle_addr[i], 8'h00);
    foreach (pages[i])
    begin
      i_host.wr(8'h04, pages[i][15:8], 1'b0);
      i_host.wr(8'h03, pages[i][7:0], 1'b0);
      @(negedge core_clk_i);
      check(link_bank_page_selector_o, pages[i]);
      check(16'({link_page_main_o, link_page_digital_o, link_page_analog_o}), 16'(3'b100 >> i));
    end
    rnd = 8'($urandom);
    for (int m = 0; m < 3; m++)
    begin
      i_host.wr(8'h05, {7'h00, m != 0}, 1'b0);
      i_host.wr(8'h41, rnd + 8'(m), m == 2);
      check(16'({chan_a_wr_o, chan_b_wr_o}), (m == 0) ? 16'h3 : 16'(3 - m));
      check(16'(paged_data_o), 16'(8'(rnd + 8'(m))));
    end
    i_host.wr(8'h11, 8'h0F, 1'b0);
    @(negedge core_clk_i);
    check(16'({conv_page_master_o, conv_page_core_o}), 16'h1);
    i_host.wr(8'h11, 8'h80, 1'b0);
    rd(8'h11, 8'h80);
    i_host.wr(8'h55, 8'h01, 1'b0);
    i_host.wr(8'h21, 8'hC0, 1'b0);
    i_host.wr(8'h23, rnd, 1'b0);
    i_host.wr(8'h24, 8'h30, 1'b0);
    foreach (core_val[i])
    begin
      i_host.wr(8'h20, core_val[i], 1'b0);
      masks({core_val[i], 4'hC});
    end
    i_host.wr(8'h26, 8'h20, 1'b0);
    masks({rnd, 4'h3});
    rd(8'h26, 8'h20);
    rd(8'h21, 8'hC0);
    i_host.wr(8'h55, 8'h00, 1'b0);
    masks(12'h000);
    foreach (rst_val[i])
    begin
      i_host.wr(8'h03, 8'h5A, 1'b0);
      i_host.wr(8'h00, rst_val[i], 1'b0);
      check(16'(soft_reset_o), 16'h1);
      @(negedge core_clk_i);
      check(16'(soft_reset_o), 16'h0);
      rd(8'h03, 8'h00);
    end
    // Soft reset left the master page off and pair writes on
    i_host.wr(8'h20, rnd, 1'b0);
    check(16'({chan_a_wr_o, chan_b_wr_o}), 16'h3);
    rd(8'h20, 8'h00);
    for (int k = 0; k < 20 && exp_q.size() > 0; k++) @(negedge core_clk_i);
    if (exp_q.size() != 0) mismatches++;
    give_verdict();
  end
endmodule // testbench
